// >>> rtl/cic_pkg.sv
package cic_pkg;

   // ==========================================================================
   // Channel count, parameter indices and request layout
   // ==========================================================================
   localparam int CIC_CHANNELS = 8;
   localparam logic [7:0] PARAM_LEN = 8'h02;
   localparam logic [7:0] IDX_HI_CAL = 8'h24;
   localparam logic [7:0] IDX_LO_OFFSET = 8'h00;
   localparam logic [7:0] IDX_LO_MAXCNT = 8'h01;
   localparam logic [7:0] SUB_FIRST = 8'h01;
   localparam logic [7:0] SUB_LAST = 8'h08;

   // ==========================================================================
   // Calibration limits and reset values
   // ==========================================================================
   localparam logic signed [15:0] OFFSET_MIN = 16'hfd01;
   localparam logic signed [15:0] OFFSET_MAX = 16'h02ff;
   localparam logic signed [15:0] OFFSET_RESET = 16'h0000;
   localparam logic signed [15:0] MAXCNT_MIN = 16'h7a01;
   localparam logic signed [15:0] MAXCNT_MAX = 16'h7fff;
   localparam logic signed [15:0] FULL_SCALE = 16'h7d00;
   localparam logic signed [15:0] MAXCNT_RESET = FULL_SCALE;

   // ==========================================================================
   // Ideal count per range, input current given in microamperes
   // ==========================================================================
   localparam logic RANGE_4_20 = 1'b0;
   localparam logic RANGE_0_20 = 1'b1;
   localparam logic signed [31:0] LOW_4_20_UA = 32'h0000_0fa0;
   localparam logic signed [31:0] COUNTS_PER_MA_4_20 = 32'h0000_07d0;
   localparam logic signed [31:0] COUNTS_PER_MA_0_20 = 32'h0000_0640;
   localparam logic signed [31:0] UA_PER_MA = 32'h0000_03e8;
   localparam int DIV_STEPS = 32;

   typedef enum {ST_IDLE, ST_START, ST_WAIT, ST_PUSH} cic_state_e;

   typedef struct packed {
      logic [2:0] chan;
      logic [15:0] ua;
   } cic_smp_s;

   typedef struct packed {
      logic wr;
      logic [7:0] len;
      logic [7:0] idx_lo;
      logic [7:0] idx_hi;
      logic [7:0] sub;
      logic [7:0] data1;
      logic [7:0] data2;
   } cic_req_s;

   typedef struct packed {
      logic ok;
      logic [7:0] data1;
      logic [7:0] data2;
   } cic_rsp_s;

   typedef struct packed {
      logic [2:0] chan;
      logic rng;
      logic signed [15:0] count;
   } cic_out_s;

   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767) return 16'h7fff;
      if (v < -32'sd32768) return 16'h8000;
      return v[15:0];
   endfunction

   function automatic logic signed [31:0] ideal_count(input logic [15:0] ua, input logic rng);
      logic signed [31:0] u;
      u = signed'({16'h0000, ua});
      if (rng == RANGE_4_20) return ((u - LOW_4_20_UA) * COUNTS_PER_MA_4_20) / UA_PER_MA;
      return (u * COUNTS_PER_MA_0_20) / UA_PER_MA;
   endfunction

endpackage

// >>> rtl/cic_fifo.sv
`timescale 1ns/1ps
module cic_fifo #(
   parameter int W = 20,
   parameter int DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop, full, empty;

   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty = (wr_q == rd_q);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_q[AW-1:0]];
   assign push = i_in_valid && !full;
   assign pop = i_out_ready && !empty;

   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   fifo_level_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("fifo holds more than its depth");
endmodule

// >>> rtl/cic_div.sv
`timescale 1ns/1ps
module cic_div #(
   parameter int NW = 32,
   parameter int DW = 17
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic signed [NW-1:0] i_num,
   input wire logic [DW-1:0] i_den,
   output logic o_busy,
   output logic o_done,
   output logic signed [NW-1:0] o_quo
);
   localparam int CW = $clog2(NW);
   logic [CW-1:0] cnt_q, cnt_d;
   logic [NW-1:0] quo_q, quo_d;
   logic [DW:0] rem_q, rem_d, trial;
   logic [DW-1:0] den_q, den_d;
   logic neg_q, neg_d, busy_q, busy_d, done_q, done_d;
   logic signed [NW-1:0] res_q, res_d;

   // Restoring division on magnitudes, one quotient bit per cycle; sign fixed at the end.
   always_comb begin
      cnt_d = cnt_q;
      quo_d = quo_q;
      rem_d = rem_q;
      den_d = den_q;
      neg_d = neg_q;
      busy_d = busy_q;
      res_d = res_q;
      done_d = 1'b0;
      trial = {rem_q[DW-1:0], quo_q[NW-1]};
      if (i_start && !busy_q) begin
         busy_d = 1'b1;
         neg_d = i_num[NW-1];
         quo_d = i_num[NW-1] ? -i_num : i_num;
         rem_d = '0;
         den_d = i_den;
         cnt_d = '0;
      end else if (busy_q) begin
         quo_d = {quo_q[NW-2:0], 1'b0};
         if (trial >= {1'b0, den_q}) begin
            rem_d = trial - {1'b0, den_q};
            quo_d[0] = 1'b1;
         end else begin
            rem_d = trial;
         end
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == CW'(NW-1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            res_d = neg_q ? -signed'(quo_d) : signed'(quo_d);
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= '0;
         quo_q <= '0;
         rem_q <= '0;
         den_q <= '0;
         neg_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         res_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         quo_q <= quo_d;
         rem_q <= rem_d;
         den_q <= den_d;
         neg_q <= neg_d;
         busy_q <= busy_d;
         done_q <= done_d;
         res_q <= res_d;
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_quo = res_q;

   div_latency_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_start && !busy_q) |-> !done_q [*2] ##31 !done_q ##1 done_q) else $error("divider latency wrong");
endmodule

// >>> rtl/cic_calib.sv
`timescale 1ns/1ps
// Operation
// - Offset accepted only from -767 to +767, two's complement 0xFD01..0x02FF.
// - Every channel offset is zero after reset.
// - Maximum count accepted only from 31233 to 32767.
// - Every channel maximum count is 32000 after reset.
// - Offset and maximum count are stored separately per channel.
// - Offset corrects the range bottom, maximum count the range top.
// - Raw equal offset reads 0, raw equal maximum reads 32000, linear between.
// - In 4 to 20 mA, ideal count is (current minus 4 mA) times 2000.
// - In 0 to 20 mA, ideal count is current times 1600.
// - Offset is held and reported as signed sixteen-bit value.
// - Data byte 1 carries the low byte, data byte 2 the high byte.
// - Full physical span is measured regardless of calibration values.
// - Eight channels, each 4 to 20 mA by default or 0 to 20 mA.
module cic_calib #(
   parameter int CHANNELS = cic_pkg::CIC_CHANNELS,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [CHANNELS-1:0] i_range_0_20,
   input wire logic i_smp_valid,
   output logic o_smp_ready,
   input wire cic_pkg::cic_smp_s i_smp,
   input wire logic i_req_valid,
   input wire cic_pkg::cic_req_s i_req,
   output logic o_rsp_valid,
   output cic_pkg::cic_rsp_s o_rsp,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output cic_pkg::cic_out_s o_out
);
   import cic_pkg::*;

   // ==========================================================================
   // Parameter store and request decoding
   // ==========================================================================
   logic signed [15:0] off_q [CHANNELS];
   logic signed [15:0] off_d [CHANNELS];
   logic signed [15:0] max_q [CHANNELS];
   logic signed [15:0] max_d [CHANNELS];
   logic rsp_valid_q, rsp_valid_d;
   cic_rsp_s rsp_q, rsp_d;
   logic req_shape_ok, req_is_off, req_is_max, req_val_ok, req_ok;
   logic [2:0] req_ch;
   logic signed [15:0] req_val;

   function automatic logic sub_valid(input logic [7:0] sub);
      return (sub >= SUB_FIRST) && (sub <= SUB_LAST);
   endfunction

   always_comb begin
      req_ch = 3'(i_req.sub - SUB_FIRST);
      req_val = {i_req.data2, i_req.data1};
      req_is_off = (i_req.idx_lo == IDX_LO_OFFSET);
      req_is_max = (i_req.idx_lo == IDX_LO_MAXCNT);
      req_shape_ok = (i_req.len == PARAM_LEN) && (i_req.idx_hi == IDX_HI_CAL) &&
                     (req_is_off || req_is_max) && sub_valid(i_req.sub);
      if (!i_req.wr) begin
         req_val_ok = 1'b1;
      end else if (req_is_off) begin
         req_val_ok = (req_val >= OFFSET_MIN) && (req_val <= OFFSET_MAX);
      end else begin
         req_val_ok = (req_val >= MAXCNT_MIN) && (req_val <= MAXCNT_MAX);
      end
      req_ok = req_shape_ok && req_val_ok;
   end

   // Each channel owns its own pair of words, so a write touches exactly one entry.
   always_comb begin
      off_d = off_q;
      max_d = max_q;
      rsp_valid_d = i_req_valid;
      rsp_d = '0;
      if (i_req_valid && req_ok) begin
         rsp_d.ok = 1'b1;
         if (i_req.wr && req_is_off) begin
            off_d[req_ch] = req_val;
         end else if (i_req.wr) begin
            max_d[req_ch] = req_val;
         end
         if (req_is_off) begin
            rsp_d.data1 = off_d[req_ch][7:0];
            rsp_d.data2 = off_d[req_ch][15:8];
         end else begin
            rsp_d.data1 = max_d[req_ch][7:0];
            rsp_d.data2 = max_d[req_ch][15:8];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            off_q[i] <= OFFSET_RESET;
            max_q[i] <= MAXCNT_RESET;
         end
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         off_q <= off_d;
         max_q <= max_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_q <= rsp_d;
      end
   end

   assign o_rsp_valid = rsp_valid_q;
   assign o_rsp = rsp_q;

   // ==========================================================================
   // Sample path: ideal count, calibration, hand-off to the FIFO
   // ==========================================================================
   cic_state_e st_q, st_d;
   logic [2:0] cur_ch_q, cur_ch_d;
   logic cur_rng_q, cur_rng_d;
   logic signed [15:0] cur_ideal_q, cur_ideal_d;
   logic signed [15:0] cur_off_q, cur_off_d;
   logic signed [15:0] cur_max_q, cur_max_d;
   logic signed [15:0] res_q, res_d;
   logic div_start, div_done;
   logic signed [31:0] div_num, div_quo;
   logic [16:0] div_den;
   logic fifo_in_valid, fifo_in_ready;
   logic [$bits(cic_out_s)-1:0] fifo_dout;
   cic_out_s push_word;

   // Numerator stays under 2^31 because the ideal count is first saturated to sixteen bits.
   assign div_num = 32'(32'(signed'(cur_ideal_q) - signed'(cur_off_q)) * signed'(32'(FULL_SCALE)));
   assign div_den = 17'(signed'(17'(cur_max_q)) - signed'(17'(cur_off_q)));

   always_comb begin
      st_d = st_q;
      cur_ch_d = cur_ch_q;
      cur_rng_d = cur_rng_q;
      cur_ideal_d = cur_ideal_q;
      cur_off_d = cur_off_q;
      cur_max_d = cur_max_q;
      res_d = res_q;
      div_start = 1'b0;
      fifo_in_valid = 1'b0;
      o_smp_ready = 1'b0;
      case (st_q)
         ST_IDLE: begin
            o_smp_ready = 1'b1;
            if (i_smp_valid) begin
               cur_ch_d = i_smp.chan;
               cur_rng_d = i_range_0_20[i_smp.chan];
               // No clamp to the calibration points keeps readings beyond both ends visible.
               cur_ideal_d = sat16(ideal_count(i_smp.ua, i_range_0_20[i_smp.chan]));
               cur_off_d = off_q[i_smp.chan];
               cur_max_d = max_q[i_smp.chan];
               st_d = ST_START;
            end
         end
         ST_START: begin
            div_start = 1'b1;
            st_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (div_done) begin
               res_d = sat16(div_quo);
               st_d = ST_PUSH;
            end
         end
         ST_PUSH: begin
            fifo_in_valid = 1'b1;
            if (fifo_in_ready) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= ST_IDLE;
         cur_ch_q <= '0;
         cur_rng_q <= RANGE_4_20;
         cur_ideal_q <= '0;
         cur_off_q <= OFFSET_RESET;
         cur_max_q <= MAXCNT_RESET;
         res_q <= '0;
      end else begin
         st_q <= st_d;
         cur_ch_q <= cur_ch_d;
         cur_rng_q <= cur_rng_d;
         cur_ideal_q <= cur_ideal_d;
         cur_off_q <= cur_off_d;
         cur_max_q <= cur_max_d;
         res_q <= res_d;
      end
   end

   cic_div #(
      .NW(DIV_STEPS),
      .DW(17)
   ) u_div (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_start(div_start),
      .i_num(div_num),
      .i_den(div_den),
      .o_busy(),
      .o_done(div_done),
      .o_quo(div_quo)
   );

   always_comb begin
      push_word.chan = cur_ch_q;
      push_word.rng = cur_rng_q;
      push_word.count = res_q;
   end

   // A stalled reader fills the FIFO and then holds the state machine in ST_PUSH.
   cic_fifo #(
      .W($bits(cic_out_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(push_word),
      .o_out_valid(o_out_valid),
      .i_out_ready(i_out_ready),
      .o_out_data(fifo_dout)
   );

   assign o_out = cic_out_s'(fifo_dout);

   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   logic [CHANNELS-1:0] off_wr_seen_q, max_wr_seen_q;
   logic [16*CHANNELS-1:0] off_flat, max_flat, ch_mask;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         off_wr_seen_q <= '0;
         max_wr_seen_q <= '0;
      end else if (i_req_valid && req_ok && i_req.wr) begin
         off_wr_seen_q[req_ch] <= off_wr_seen_q[req_ch] | req_is_off;
         max_wr_seen_q[req_ch] <= max_wr_seen_q[req_ch] | req_is_max;
      end
   end

   // Flattened copies let one property compare every channel at once.
   always_comb begin
      ch_mask = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         off_flat[16*i +: 16] = off_q[i];
         max_flat[16*i +: 16] = max_q[i];
      end
      ch_mask[16*req_ch +: 16] = 16'hffff;
   end

   logic [5:0] wait_run_q, wait_run_d;

   // Counts divider wait cycles so the flow check needs no long repetition.
   always_comb begin
      wait_run_d = 6'h00;
      if (st_q == ST_WAIT) begin
         wait_run_d = wait_run_q + 6'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_run_q <= 6'h00;
      end else begin
         wait_run_q <= wait_run_d;
      end
   end

   sequence accept_smp;
      st_q == ST_IDLE && i_smp_valid;
   endsequence

   sequence good_write;
      i_req_valid && req_ok && i_req.wr;
   endsequence

   off_limits_a: assert property (off_q[cur_ch_q] >= OFFSET_MIN && off_q[cur_ch_q] <= OFFSET_MAX)
      else $error("stored offset outside limits");
   max_limits_a: assert property (max_q[cur_ch_q] >= MAXCNT_MIN && max_q[cur_ch_q] <= MAXCNT_MAX)
      else $error("stored maximum count outside limits");
   off_default_a: assert property (!off_wr_seen_q[cur_ch_q] |-> off_q[cur_ch_q] == OFFSET_RESET)
      else $error("unconfigured offset not zero");
   max_default_a: assert property (!max_wr_seen_q[cur_ch_q] |-> max_q[cur_ch_q] == MAXCNT_RESET)
      else $error("unconfigured maximum count not default");
   other_chan_a: assert property (good_write |=>
      ((off_flat ^ $past(off_flat)) & ~$past(ch_mask)) == '0 && ((max_flat ^ $past(max_flat)) & ~$past(ch_mask)) == '0)
      else $error("write changed another channel");
   req_refuse_a: assert property ((i_req_valid && !req_ok) |=>
      o_rsp_valid && !o_rsp.ok && $stable(off_flat) && $stable(max_flat))
      else $error("bad request not refused");
   rsp_bytes_a: assert property ((i_req_valid && req_ok && !i_req.wr && req_is_off) |=>
      o_rsp.ok && {o_rsp.data2, o_rsp.data1} == $past(off_flat[16*req_ch +: 16]))
      else $error("offset read bytes wrong");
   ideal_420_a: assert property ((accept_smp ##0 !i_range_0_20[i_smp.chan]) |=>
      cur_ideal_q == sat16(($past(signed'({16'h0000, i_smp.ua})) - 32'sd4000) * 32'sd2))
      else $error("4-20 ideal count wrong");
   ideal_020_a: assert property ((accept_smp ##0 i_range_0_20[i_smp.chan]) |=>
      cur_ideal_q == sat16(($past(signed'({16'h0000, i_smp.ua})) * 32'sd8) / 32'sd5))
      else $error("0-20 ideal count wrong");
   cal_low_a: assert property ((st_q == ST_WAIT && div_done && cur_ideal_q == cur_off_q) |=> res_q == 16'sh0000)
      else $error("offset point not zero");
   cal_high_a: assert property ((st_q == ST_WAIT && div_done && cur_ideal_q == cur_max_q) |=> res_q == FULL_SCALE)
      else $error("maximum point not full scale");
   smp_flow_a: assert property (accept_smp |=> st_q == ST_START ##1 st_q == ST_WAIT ##32
      (st_q == ST_WAIT && wait_run_q == 6'(DIV_STEPS)) ##1 st_q == ST_PUSH)
      else $error("sample flow timing wrong");

   sequence off_write;
      good_write ##0 req_is_off;
   endsequence

   sequence max_write;
      good_write ##0 req_is_max;
   endsequence

   rsp_pulse_a: assert property (o_rsp_valid == $past(i_req_valid))
      else $error("response pulse missing");
   off_store_a: assert property (off_write |=>
      off_q[$past(req_ch)] == $past(req_val))
      else $error("offset write not stored");
   max_store_a: assert property (max_write |=>
      max_q[$past(req_ch)] == $past(req_val))
      else $error("maximum count write not stored");
   rsp_max_a: assert property ((i_req_valid && req_ok && !i_req.wr && req_is_max) |=>
      o_rsp.ok && {o_rsp.data2, o_rsp.data1} == $past(max_flat[16*req_ch +: 16]))
      else $error("maximum count read bytes wrong");
   push_stall_a: assert property ((st_q == ST_PUSH && !fifo_in_ready) |=> st_q == ST_PUSH && $stable(res_q))
      else $error("result lost while buffer full");
endmodule

// >>> dv/cic_nim_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Network interface side: one runtime parameter access at a time
// ==========================================================================
module cic_nim_model
   import cic_pkg::*;
(
   input wire logic i_mclk,
   output logic o_req_valid,
   output cic_pkg::cic_req_s o_req,
   input wire logic i_rsp_valid,
   input wire cic_pkg::cic_rsp_s i_rsp
);
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
   end

   // Length and index are arguments so that the bench can command broken request blocks.
   task automatic access(input logic wr, input logic [7:0] len, input logic [7:0] hi, input logic [7:0] lo,
      input logic [7:0] sub, input logic [15:0] val, output logic ok, output logic [15:0] rd, output logic got);
      logic seen;
      seen = 1'b0;
      got = 1'b0;
      ok = 1'b0;
      rd = 16'h0000;
      @(negedge i_mclk);
      o_req <= '{wr, len, lo, hi, sub, val[7:0], val[15:8]};
      o_req_valid <= 1'b1;
      // The answer stands in the cycle after the taking edge, so it is read at the next falling edge.
      for (int n = 0; n < 4; n++) begin
         @(negedge i_mclk);
         if (n == 0) begin
            o_req_valid <= 1'b0;
            // A released block shows the inverse of its last value, so a late capture cannot pass by luck.
            o_req <= ~o_req;
         end
         if (!seen && i_rsp_valid === 1'b1) begin
            seen = 1'b1;
            got = (n == 0);
            ok = i_rsp.ok;
            rd = {i_rsp.data2, i_rsp.data1};
         end
      end
   endtask
endmodule

// >>> dv/cic_calib_bench.sv
`timescale 1ns/1ps
module cic_calib_bench;
   import cic_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] rng = 8'h00;
   logic smp_v = 1'b0;
   cic_smp_s smp = '0;
   logic smp_rdy, rsp_v, out_v, req_v;
   logic out_rdy = 1'b0;
   logic hold_out = 1'b0;
   cic_req_s req;
   cic_rsp_s rsp;
   cic_out_s out_q;
   int miscompares = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h790d;
   cic_out_s exp_q[$];
   logic signed [15:0] off[8];
   logic signed [15:0] mx[8];

   always #5 clk = ~clk;

   cic_calib #(.CHANNELS(8), .FIFO_DEPTH(8)) dut (.i_mclk(clk), .i_nrst(nrst), .i_range_0_20(rng),
      .i_smp_valid(smp_v), .o_smp_ready(smp_rdy), .i_smp(smp), .i_req_valid(req_v), .i_req(req),
      .o_rsp_valid(rsp_v), .o_rsp(rsp), .o_out_valid(out_v), .i_out_ready(out_rdy), .o_out(out_q));
   cic_nim_model nim (.i_mclk(clk), .o_req_valid(req_v), .o_req(req), .i_rsp_valid(rsp_v), .i_rsp(rsp));

   // ==========================================================================
   // Expectations
   // ==========================================================================
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic signed [15:0] clip(input longint v);
      return v > 16'sh7fff ? 16'sh7fff : v < 16'sh8000 ? 16'sh8000 : v[15:0];
   endfunction

   function automatic logic signed [15:0] calc(input logic [2:0] ch, input logic r, input logic [15:0] ua);
      longint raw;
      raw = r ? longint'(ua) * 16'sh0640 / 16'sh03e8 : (longint'(ua) - 16'sh0fa0) * 16'sh07d0 / 16'sh03e8;
      raw = clip(raw);
      return clip((raw - off[ch]) * 16'sh7d00 / (mx[ch] - off[ch]));
   endfunction

   // ==========================================================================
   // Checks and closing
   // ==========================================================================
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic hang(input string what);
      miscompares++;
      $display("unexpected %s expected done seen timeout", what);
      wrap_up();
   endtask

   task automatic par(input logic wr, input logic [7:0] len, input logic [7:0] hi, input logic [7:0] lo,
      input logic [7:0] sub, input logic [15:0] v, input logic ok_e, input logic [15:0] rd_e);
      logic ok, got;
      logic [15:0] rd;
      nim.access(wr, len, hi, lo, sub, v, ok, rd, got);
      chk("response timing", 32'h1, got);
      chk("response ok", ok_e, ok);
      chk("response data", rd_e, rd);
   endtask

   task automatic setp(input logic [7:0] lo, input logic [7:0] sub, input logic [15:0] v);
      logic good;
      good = sub >= 8'h01 && sub <= 8'h08 && (lo == 8'h00 ? ($signed(v) >= 16'shfd01 && $signed(v) <= 16'sh02ff)
         : (v >= 16'h7a01 && v <= 16'h7fff));
      if (good && lo == 8'h00)
         off[3'(sub - 8'h01)] = v;
      if (good && lo != 8'h00)
         mx[3'(sub - 8'h01)] = v;
      par(1'b1, 8'h02, 8'h24, lo, sub, v, good, good ? v : 16'h0000);
   endtask

   task automatic getp(input logic [7:0] lo, input logic [7:0] sub);
      par(1'b0, 8'h02, 8'h24, lo, sub, 16'h0000, 1'b1, lo == 8'h00 ? off[3'(sub - 8'h01)] : mx[3'(sub - 8'h01)]);
   endtask

   task automatic send(input logic [2:0] ch, input logic r, input logic [15:0] ua);
      int n;
      n = 0;
      @(negedge clk);
      while (smp_rdy !== 1'b1 && n < 200) begin
         n++;
         @(negedge clk);
      end
      if (n == 200)
         hang("sample ready");
      smp_v <= 1'b1;
      smp <= '{ch, ua};
      rng[ch] <= r;
      exp_q.push_back('{ch, r, calc(ch, r, ua)});
      @(negedge clk);
      smp_v <= 1'b0;
      smp <= ~smp;
   endtask

   task automatic drain(input string name);
      int n;
      n = 0;
      while ((exp_q.size() != 0 || out_v !== 1'b0) && n < 3000) begin
         n++;
         @(negedge clk);
      end
      if (n == 3000)
         hang("output drain");
      $display("test %s done", name);
   endtask

   // The reader stalls about one cycle in four so that results wait in the buffer.
   always @(negedge clk) begin
      out_rdy <= !hold_out && (xs() & 32'h3) != 32'h0;
   end

   always @(posedge clk) begin
      if (nrst && out_v === 1'b1 && out_rdy === 1'b1) begin
         if (exp_q.size() == 0)
            chk("spurious output", 32'h0, 32'h1);
         else
            chk("calibrated output", exp_q.pop_front(), out_q);
      end
   end

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   initial begin
      for (int i = 0; i < 8; i++) begin
         off[i] = 16'h0000;
         mx[i] = 16'h7d00;
      end
      repeat (4) @(negedge clk);
      nrst <= 1'b1;
      for (int c = 1; c <= 8; c++) begin
         getp(8'h00, 8'(c));
         getp(8'h01, 8'(c));
      end
      $display("test defaults done");
      setp(8'h00, 8'h01, 16'hfd01);
      setp(8'h00, 8'h01, 16'h02ff);
      setp(8'h00, 8'h01, 16'hfd00);
      setp(8'h00, 8'h01, 16'h0300);
      setp(8'h01, 8'h02, 16'h7a01);
      setp(8'h01, 8'h02, 16'h7fff);
      setp(8'h01, 8'h02, 16'h7a00);
      setp(8'h01, 8'h02, 16'h8000);
      setp(8'h00, 8'h00, 16'h0010);
      setp(8'h01, 8'h09, 16'h7b00);
      par(1'b1, 8'h01, 8'h24, 8'h00, 8'h01, 16'h0005, 1'b0, 16'h0000);
      par(1'b1, 8'h02, 8'h25, 8'h00, 8'h01, 16'h0005, 1'b0, 16'h0000);
      par(1'b1, 8'h02, 8'h24, 8'h02, 8'h01, 16'h0005, 1'b0, 16'h0000);
      getp(8'h00, 8'h01);
      getp(8'h01, 8'h02);
      setp(8'h00, 8'h01, 16'h0000);
      setp(8'h01, 8'h02, 16'h7d00);
      setp(8'h00, 8'h03, 16'h0040);
      setp(8'h01, 8'h03, 16'h7c00);
      getp(8'h00, 8'h02);
      getp(8'h01, 8'h04);
      $display("test parameters done");
      send(3'h2, 1'b0, 16'h0fc0);
      send(3'h2, 1'b0, 16'h3e28);
      send(3'h2, 1'b0, 16'h4e20);
      send(3'h2, 1'b0, 16'h4da0);
      send(3'h2, 1'b1, 16'h0028);
      send(3'h2, 1'b1, 16'h3a2a);
      send(3'h2, 1'b1, 16'h4d80);
      send(3'h0, 1'b0, 16'h2ee0);
      send(3'h1, 1'b1, 16'h4e20);
      send(3'h7, 1'b0, 16'h0000);
      drain("calibration points");
      @(posedge clk);
      hold_out = 1'b1;
      for (int i = 0; i < 9; i++)
         send(3'(i), 1'b0, 16'h1f40);
      repeat (40) @(negedge clk);
      chk("sample ready while full", 32'h0, smp_rdy);
      chk("output valid while full", 32'h1, out_v);
      @(posedge clk);
      hold_out = 1'b0;
      drain("buffer full");
      for (int c = 1; c <= 8; c++) begin
         setp(8'h00, 8'(c), 16'(xs() % 32'h5ff) - 16'h02ff);
         setp(8'h01, 8'(c), 16'h7a01 + 16'(xs() % 32'h5ff));
      end
      for (int i = 0; i < 40; i++)
         send(3'(xs()), 1'(xs()), 16'(xs() % 32'h5dc1));
      drain("random samples");
      wrap_up();
   end
endmodule
